//--- spps_assertions.sv
// Purpose: port-level assertions for spps_top
// Assumes: register writes are mirrored here from the port
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module spps_assertions (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic paperSenseIn,
	input wire logic [7:0] regRdata,
	input wire logic windingPwm,
	input wire logic paperPresent,
	input wire logic irq
);
	// writable bits of registers 0..8
	localparam logic [7:0] WM [0:8] = '{8'h07, 8'h1f, 8'hff, 8'h3f, 8'h3f,
		8'h01, 8'h00, 8'h00, 8'h07};
	logic [7:0] mir [0:8]; // register mirror
	logic [17:0] lowCnt; // low stretch while a floor is set
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// mirror software writes
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mir <= '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		end else if (regWr && regAddr <= 4'h8) begin
			mir[regAddr] <= regWdata & WM[regAddr];
		end
	end
	// count low cycles; a floor must break any long run
	always_ff @(posedge core_clk) begin
		if (!resetn || windingPwm || mir[3] == 8'h00) begin
			lowCnt <= 18'h00000;
		end else begin
			lowCnt <= lowCnt + 18'h00001;
		end
	end
	property p_rdIdle; !regRd |=> regRdata == 8'h00; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("stray read data");
	property p_rdCfg; regRd && (regAddr <= 4'h5 || regAddr == 4'h8)
		|=> regRdata == $past(mir[regAddr]); endproperty
	a_rdCfg: assert property (p_rdCfg) else $error("config readback");
	property p_rdUnmap; regRd && regAddr > 4'h8 |=> regRdata == 8'h00;
	endproperty
	a_rdUnmap: assert property (p_rdUnmap) else $error("unmapped read");
	property p_rdState; regRd && regAddr == 4'h6 |=> regRdata[7:3] == 5'h00
		&& regRdata[0] == $past(paperPresent); endproperty
	a_rdState: assert property (p_rdState) else $error("state read");
	property p_rdIntHi; regRd && regAddr == 4'h7 |=> regRdata[7:3] == 5'h00;
	endproperty
	a_rdIntHi: assert property (p_rdIntHi) else $error("status read");
	property p_paperPol; $past(resetn) |=> paperPresent ==
		($past(paperSenseIn) ~^ $past(mir[5][0])); endproperty
	a_paperPol: assert property (p_paperPol) else $error("paper level");
	property p_irqMask; mir[8] == 8'h00 && $past(mir[8]) == 8'h00 |-> !irq;
	endproperty
	a_irqMask: assert property (p_irqMask) else $error("masked irq");
	// with a floor of one or more, phase 0 is always driven, so a low run
	// spans at most 63 steps of at most 1024 clocks; a lost floor with zero
	// demand stays low for a whole 65536-clock period and trips this
	property p_floor; lowCnt < 18'h10000; endproperty
	a_floor: assert property (p_floor) else $error("duty floor lost");
endmodule : spps_assertions
`default_nettype wire

//--- spps_partner.sv
// Purpose: far side model: paper switch and winding current watcher
// Assumes: closed switch grounds the line, a pull-up holds it high
// Notes: reports the last finished high and low run of the drive
`timescale 1ns/1ps
`default_nettype none
module spps_partner (
	input wire logic core_clk,
	input wire logic windingPwm,
	input wire logic paperIn,
	output logic paperSenseIn,
	output logic [17:0] hiLen,
	output logic [17:0] loLen
);
	logic prevPwm = 1'b0; // drive level last cycle
	logic [17:0] runCnt = 18'h00000; // cycles at that level
	// paper closes the switch to ground
	assign paperSenseIn = !paperIn;
	// record each finished run of the drive
	always_ff @(posedge core_clk) begin
		prevPwm <= windingPwm;
		if (windingPwm != prevPwm) begin
			runCnt <= 18'h00001;
			if (prevPwm) begin
				hiLen <= runCnt;
			end else begin
				loLen <= runCnt;
			end
		end else begin
			runCnt <= runCnt + 18'h00001;
		end
	end
endmodule : spps_partner
`default_nettype wire

//--- spps_pkg.sv
// Purpose: shared constants and types of the stepper pwm / paper sense block
// Assumes: 8-bit register port, one 10 MHz clock
// Notes: every offset, field position and reset value lives here
package spps_pkg;
	// register indices on the plain register port
	localparam logic [3:0] REG_KICK = 4'h0; // kickstart full steps
	localparam logic [3:0] REG_HOLD = 4'h1; // hold-current timeout
	localparam logic [3:0] REG_PWMFREQ = 4'h2; // pwm frequency divisor
	localparam logic [3:0] REG_MINDUTY = 4'h3; // minimum pwm duty
	localparam logic [3:0] REG_DEMAND = 4'h4; // requested winding duty
	localparam logic [3:0] REG_PAPER = 4'h5; // paper sense polarity
	localparam logic [3:0] REG_STATE = 4'h6; // live state, read only
	localparam logic [3:0] REG_INTSTAT = 4'h7; // sticky events, read clears
	localparam logic [3:0] REG_INTMASK = 4'h8; // interrupt mask

	// field widths and positions
	localparam int KICK_W = 3;
	localparam int HOLD_W = 5;
	localparam int FREQ_W = 8;
	localparam int DUTY_W = 6;
	localparam int EVT_W = 3;
	localparam int EVT_PAPER = 0; // paper state changed
	localparam int EVT_KICKDONE = 1; // kickstart finished
	localparam int EVT_HOLDOUT = 2; // hold timeout expired
	localparam int ST_PAPER = 0; // state bit: paper present
	localparam int ST_KICK = 1; // state bit: kickstart running
	localparam int ST_HOLD = 2; // state bit: hold timed out

	// pwm shape: 64 phase steps, each 4*n clocks, so period 256*n
	localparam int PHASE_STEPS = 64;
	localparam int PRESCALE_MULT = 4;
	localparam logic [8:0] FREQ_ZERO_DIV = 9'h100; // n = 0 acts as 256
	localparam int PRE_W = 10;

	// reset values
	localparam logic [KICK_W-1:0] KICK_RST = 3'h0;
	localparam logic [HOLD_W-1:0] HOLD_RST = 5'h01;
	localparam logic [FREQ_W-1:0] FREQ_RST = 8'h00;
	localparam logic [DUTY_W-1:0] MINDUTY_RST = 6'h00;
	localparam logic [DUTY_W-1:0] DEMAND_RST = 6'h00;
	localparam logic POL_RST = 1'b0;
	localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

	// software configuration, grouped
	typedef struct packed {
		logic [KICK_W-1:0] kickN; // full-current steps at start
		logic [HOLD_W-1:0] holdN; // hold timeout in step units
		logic [FREQ_W-1:0] pwmFreq; // pwm divisor setting
		logic [DUTY_W-1:0] minDuty; // duty floor in 64ths
		logic [DUTY_W-1:0] demandDuty; // normal running duty
		logic polHigh; // 1: high input means paper
		logic [EVT_W-1:0] intMask; // per-event enable
	} spps_cfg_s;

	// whole state of the top module
	typedef struct packed {
		spps_cfg_s cfg; // configuration
		logic [EVT_W-1:0] intStat; // sticky events
		logic paperState; // polarity-corrected sense level
		logic motorPrev; // run level last cycle
		logic [KICK_W-1:0] kickCnt; // kickstart steps left
		logic [HOLD_W-1:0] holdCnt; // idle units counted
		logic holdExpired; // idle timeout reached
		logic [DUTY_W-1:0] phase; // pwm phase
		logic windingOn; // pwm output
		logic irq; // interrupt output
		logic [7:0] rdData; // read data
	} spps_state_s;

	// state of the pwm prescaler
	typedef struct packed {
		logic [PRE_W-1:0] cnt; // clocks within one phase step
		logic stepEn; // one-cycle enable
	} spps_pre_s;
endpackage : spps_pkg

//--- spps_pwm_div.sv
// Purpose: prescaler giving one enable per pwm phase step
// Assumes: freqN sampled every cycle; a change sets the end of the step in progress
// Notes: step length is 4*n clocks, n = 0 treated as 256
`timescale 1ns/1ps
`default_nettype none
module spps_pwm_div (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [spps_pkg::FREQ_W-1:0] freqN,
	output logic stepEn
);
	spps_pkg::spps_pre_s preReg; // registered state
	spps_pkg::spps_pre_s preNext; // next state
	logic [8:0] divisor; // effective divisor 1..256
	logic [spps_pkg::PRE_W-1:0] lastCnt; // terminal count

	// divisor and terminal count
	always_comb begin
		if (freqN == '0) begin
			divisor = spps_pkg::FREQ_ZERO_DIV; // RULE4
		end else begin
			divisor = {1'b0, freqN}; // RULE3
		end
		lastCnt = spps_pkg::PRE_W'({divisor, 1'b0, 1'b0} - 11'h001); // RULE3
	end

	// counter with a pulse on wrap
	always_comb begin
		preNext = preReg;
		preNext.stepEn = 1'b0;
		if (preReg.cnt >= lastCnt) begin
			preNext.cnt = '0;
			preNext.stepEn = 1'b1;
		end else begin
			preNext.cnt = preReg.cnt + 10'h001;
		end
	end

	// register
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			preReg <= '0;
		end else begin
			preReg <= preNext;
		end
	end

	assign stepEn = preReg.stepEn;
endmodule : spps_pwm_div
`default_nettype wire

//--- spps_top.sv
// Purpose: stepper winding pwm with kickstart, hold timeout, duty floor,
//   and level-sensitive paper sense with interrupt
// Assumes: stepTick pulses once per full step time unit; inputs synchronous
// Notes: pwm period is 256*n clocks of core_clk
//
// Contract
// RULE1: full current for first n steps (0-7); code loads the kickstart only if fullStepMode is high when motorRun rises
// RULE2: software keeps hold timeout 1..31, never 0
// RULE3: pwm rate is clock over 256*n
// RULE4: setting zero gives clock over 65536
// RULE5: duty never below minimum n/64
// RULE6: polarity picks low or high as paper
// RULE7: state bit set while paper input true
// RULE8: winding active while phase below duty
`timescale 1ns/1ps
`default_nettype none
module spps_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic motorRun,
	input wire logic fullStepMode,
	input wire logic stepTick,
	input wire logic paperSenseIn,
	output logic [7:0] regRdata,
	output logic windingPwm,
	output logic paperPresent,
	output logic irq
);
	spps_pkg::spps_state_s stReg; // registered state
	spps_pkg::spps_state_s stNext; // next state
	logic phaseEn; // one pulse per phase step
	logic [spps_pkg::DUTY_W:0] baseDuty; // duty before the floor
	logic [spps_pkg::DUTY_W:0] effDuty; // duty after the floor
	logic [spps_pkg::EVT_W-1:0] evt; // events this cycle
	logic paperNow; // corrected sense level
	logic startEdge; // motor starting this cycle

	// phase step enable from the divider
	spps_pwm_div uDiv (
		.core_clk(core_clk),
		.resetn(resetn),
		.freqN(stReg.cfg.pwmFreq),
		.stepEn(phaseEn)
	);

	// duty selection: kickstart, hold, normal, then the floor
	always_comb begin
		if (stReg.kickCnt != '0) begin
			baseDuty = 7'(spps_pkg::PHASE_STEPS); // RULE1
		end else if (stReg.holdExpired) begin
			baseDuty = '0; // current dropped after idle timeout
		end else begin
			baseDuty = {1'b0, stReg.cfg.demandDuty};
		end
		if (baseDuty < {1'b0, stReg.cfg.minDuty}) begin
			effDuty = {1'b0, stReg.cfg.minDuty}; // RULE5
		end else begin
			effDuty = baseDuty;
		end
	end

	// input conditioning
	always_comb begin
		paperNow = stReg.cfg.polHigh ? paperSenseIn : !paperSenseIn; // RULE6
		startEdge = motorRun && !stReg.motorPrev;
	end

	// next-state logic
	always_comb begin
		stNext = stReg;
		evt = '0;
		stNext.motorPrev = motorRun;

		// paper state follows the level
		stNext.paperState = paperNow; // RULE7
		if (paperNow != stReg.paperState) begin
			evt[spps_pkg::EVT_PAPER] = 1'b1;
		end

		// kickstart counter
		if (startEdge && fullStepMode) begin
			stNext.kickCnt = stReg.cfg.kickN; // RULE1
		end else if (!motorRun) begin
			stNext.kickCnt = '0; // abandoned when the motor stops
		end else if (stepTick && stReg.kickCnt != '0) begin
			stNext.kickCnt = stReg.kickCnt - 3'h1; // RULE1
			if (stReg.kickCnt == 3'h1) begin
				evt[spps_pkg::EVT_KICKDONE] = 1'b1;
			end
		end

		// hold timeout counts step units while idle
		if (motorRun) begin
			stNext.holdCnt = '0;
			stNext.holdExpired = 1'b0;
		end else if (stepTick && !stReg.holdExpired) begin
			// a zero setting would expire on the first unit
			if (stReg.holdCnt + 5'h01 >= stReg.cfg.holdN) begin // RULE2
				stNext.holdExpired = 1'b1;
				evt[spps_pkg::EVT_HOLDOUT] = 1'b1;
			end else begin
				stNext.holdCnt = stReg.holdCnt + 5'h01;
			end
		end

		// pwm phase and output
		if (phaseEn) begin
			stNext.phase = stReg.phase + 6'h01;
		end
		stNext.windingOn = {1'b0, stReg.phase} < effDuty; // RULE8

		// register writes
		if (regWr) begin
			if (regAddr == spps_pkg::REG_KICK) begin
				stNext.cfg.kickN = regWdata[spps_pkg::KICK_W-1:0];
			end else if (regAddr == spps_pkg::REG_HOLD) begin
				stNext.cfg.holdN = regWdata[spps_pkg::HOLD_W-1:0];
			end else if (regAddr == spps_pkg::REG_PWMFREQ) begin
				stNext.cfg.pwmFreq = regWdata;
			end else if (regAddr == spps_pkg::REG_MINDUTY) begin
				stNext.cfg.minDuty = regWdata[spps_pkg::DUTY_W-1:0];
			end else if (regAddr == spps_pkg::REG_DEMAND) begin
				stNext.cfg.demandDuty = regWdata[spps_pkg::DUTY_W-1:0];
			end else if (regAddr == spps_pkg::REG_PAPER) begin
				stNext.cfg.polHigh = regWdata[0];
			end else if (regAddr == spps_pkg::REG_INTMASK) begin
				stNext.cfg.intMask = regWdata[spps_pkg::EVT_W-1:0];
			end
		end

		// register reads, data valid next cycle only
		stNext.rdData = '0;
		if (regRd) begin
			if (regAddr == spps_pkg::REG_KICK) begin
				stNext.rdData = {5'h00, stReg.cfg.kickN};
			end else if (regAddr == spps_pkg::REG_HOLD) begin
				stNext.rdData = {3'h0, stReg.cfg.holdN};
			end else if (regAddr == spps_pkg::REG_PWMFREQ) begin
				stNext.rdData = stReg.cfg.pwmFreq;
			end else if (regAddr == spps_pkg::REG_MINDUTY) begin
				stNext.rdData = {2'h0, stReg.cfg.minDuty};
			end else if (regAddr == spps_pkg::REG_DEMAND) begin
				stNext.rdData = {2'h0, stReg.cfg.demandDuty};
			end else if (regAddr == spps_pkg::REG_PAPER) begin
				stNext.rdData = {7'h00, stReg.cfg.polHigh};
			end else if (regAddr == spps_pkg::REG_STATE) begin
				stNext.rdData[spps_pkg::ST_PAPER] = stReg.paperState;
				stNext.rdData[spps_pkg::ST_KICK] = stReg.kickCnt != '0;
				stNext.rdData[spps_pkg::ST_HOLD] = stReg.holdExpired;
			end else if (regAddr == spps_pkg::REG_INTSTAT) begin
				stNext.rdData = {5'h00, stReg.intStat};
			end else if (regAddr == spps_pkg::REG_INTMASK) begin
				stNext.rdData = {5'h00, stReg.cfg.intMask};
			end
		end

		// sticky events: read clears, a new event wins
		if (regRd && regAddr == spps_pkg::REG_INTSTAT) begin
			stNext.intStat = evt;
		end else begin
			stNext.intStat = stReg.intStat | evt;
		end
		stNext.irq = |(stNext.intStat & stNext.cfg.intMask);
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			stReg <= '0;
			stReg.cfg.kickN <= spps_pkg::KICK_RST;
			stReg.cfg.holdN <= spps_pkg::HOLD_RST;
			stReg.cfg.pwmFreq <= spps_pkg::FREQ_RST;
			stReg.cfg.minDuty <= spps_pkg::MINDUTY_RST;
			stReg.cfg.demandDuty <= spps_pkg::DEMAND_RST;
			stReg.cfg.polHigh <= spps_pkg::POL_RST;
			stReg.cfg.intMask <= spps_pkg::MASK_RST;
		end else begin
			stReg <= stNext;
		end
	end

	// outputs straight from flops
	assign regRdata = stReg.rdData;
	assign windingPwm = stReg.windingOn;
	assign paperPresent = stReg.paperState;
	assign irq = stReg.irq;
endmodule : spps_top
`default_nettype wire

//--- spps_top_tb.sv
// Purpose: self-checking bench for spps_top
// Assumes: 10 MHz core_clk, synchronous active-low reset
// Notes: read results are checked from a queue one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module spps_top_tb;
	localparam logic [7:0] WM [0:8] = '{8'h07, 8'h1f, 8'hff, 8'h3f, 8'h3f,
		8'h01, 8'h00, 8'h00, 8'h07}; // writable bits
	localparam logic [7:0] FQ [0:2] = '{8'h01, 8'h03, 8'h00}; // divisors
	localparam logic [7:0] DM [0:2] = '{8'h20, 8'h0a, 8'h00}; // demand
	localparam logic [7:0] MN [0:2] = '{8'h00, 8'h28, 8'h3f}; // floors
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic motorRun = 1'b0;
	logic fullStepMode = 1'b0;
	logic stepTick = 1'b0;
	logic paperIn = 1'b0; // paper under the switch
	logic rdSeen = 1'b0; // read data due now
	logic paperSenseIn, windingPwm, paperPresent, irq;
	logic [7:0] regRdata, d;
	logic [17:0] hiLen, loLen;
	logic [3:0] a;
	logic [7:0] expQ [$]; // expected read data
	int num_errors = 0;
	int checked = 0;
	int seed = 32'h2822;
	int cyc = 0;
	int dv, hv;
	always #50 core_clk = ~core_clk;
	spps_top dut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .motorRun(motorRun),
		.fullStepMode(fullStepMode), .stepTick(stepTick),
		.paperSenseIn(paperSenseIn), .regRdata(regRdata),
		.windingPwm(windingPwm), .paperPresent(paperPresent), .irq(irq));
	spps_partner motorSide (.core_clk(core_clk), .windingPwm(windingPwm),
		.paperIn(paperIn), .paperSenseIn(paperSenseIn), .hiLen(hiLen),
		.loLen(loLen));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= ad;
		regWdata <= dt;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] ad, input logic [7:0] e);
		expQ.push_back(e);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= ad;
		@(posedge core_clk);
		regRd <= 1'b0;
	endtask : rd
	task automatic tick;
		@(posedge core_clk);
		stepTick <= 1'b1;
		@(posedge core_clk);
		stepTick <= 1'b0;
	endtask : tick
	// read data stands one cycle after the strobe; also the hang limit
	always @(posedge core_clk) begin
		if (rdSeen) check(32'(regRdata), 32'(expQ.pop_front()));
		rdSeen <= regRd;
		cyc++;
		if (cyc > 90000) begin
			num_errors++;
			final_report;
		end
	end
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 16; i++) rd(4'(i), (i == 1) ? 8'h01 : 8'h00);
		$display("reset values done");
		for (int i = 0; i < 16; i++) begin
			a = 4'($random(seed));
			d = 8'($random(seed));
			if (a inside {4'h5, 4'h6, 4'h7}) a = 4'h9;
			if (a == 4'h1 && d[4:0] == 5'h00) d = 8'h1f;
			wr(a, d);
			rd(a, (a > 4'h8) ? 8'h00 : d & WM[a]);
		end
		$display("random registers done");
		wr(spps_pkg::REG_INTMASK, 8'h01);
		paperIn <= 1'b1;
		repeat (4) @(posedge core_clk);
		check(32'(paperPresent), 32'h1);
		check(32'(irq), 32'h1);
		rd(spps_pkg::REG_STATE, 8'h01);
		rd(spps_pkg::REG_INTSTAT, 8'h01);
		repeat (2) @(posedge core_clk);
		check(32'(irq), 32'h0);
		wr(spps_pkg::REG_INTMASK, 8'h00);
		wr(spps_pkg::REG_PAPER, 8'h01);
		repeat (4) @(posedge core_clk);
		check(32'(paperPresent), 32'h0);
		check(32'(irq), 32'h0);
		rd(spps_pkg::REG_INTSTAT, 8'h01);
		$display("paper sense done");
		for (int i = 0; i < 3; i++) begin
			wr(spps_pkg::REG_PWMFREQ, FQ[i]);
			wr(spps_pkg::REG_DEMAND, DM[i]);
			wr(spps_pkg::REG_MINDUTY, MN[i]);
			dv = (FQ[i] == 8'h00) ? 256 : int'(FQ[i]);
			hv = 4 * dv * int'((DM[i] > MN[i]) ? DM[i] : MN[i]);
			repeat ((dv == 256) ? 67736 : 768 * dv + 1100) @(posedge core_clk);
			check(32'(loLen), 32'(256 * dv - hv));
			if (dv < 256) check(32'(hiLen), 32'(hv));
		end
		$display("pwm done");
		wr(spps_pkg::REG_MINDUTY, 8'h00);
		fullStepMode <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			wr(spps_pkg::REG_KICK, 8'(k));
			motorRun <= 1'b1;
			repeat (2) @(posedge core_clk);
			for (int i = 0; i <= k; i++) begin
				rd(spps_pkg::REG_STATE, (i < k) ? 8'h02 : 8'h00);
				if (i < k) check(32'(windingPwm), 32'h1);
				if (i < k) tick();
			end
			motorRun <= 1'b0;
			@(posedge core_clk);
		end
		rd(spps_pkg::REG_INTSTAT, 8'h02);
		$display("kickstart done");
		wr(spps_pkg::REG_HOLD, 8'h02);
		tick();
		rd(spps_pkg::REG_STATE, 8'h00);
		tick();
		rd(spps_pkg::REG_STATE, 8'h04);
		rd(spps_pkg::REG_INTSTAT, 8'h04);
		$display("hold timeout done");
		final_report;
	end
endmodule : spps_top_tb
bind spps_top spps_assertions chk (.core_clk(core_clk), .resetn(resetn),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.paperSenseIn(paperSenseIn), .regRdata(regRdata),
	.windingPwm(windingPwm), .paperPresent(paperPresent), .irq(irq));
`default_nettype wire
